/* qas_host_model.sv */
// Host serial master: opens frames, runs the serial clock, shifts control words.
// Assumes run_frame is called only while no frame is open.
`timescale 1ns/1ps
module qas_host_model (
  // Serial link
  output logic sclk_o,
  output logic cs_n_o,
  output logic din_o,
  input wire logic dout_i,
  // Captured group
  output logic [15:0] word_o,
  output int word_cnt_o
);
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    din_o = 1'b0;
    word_o = 16'h0000;
    word_cnt_o = 0;
  end
  // Whole groups of 16 rising edges, clock rest level per frame
  task automatic run_frame(input int ng, input bit hi, input logic [31:0] cw);
    sclk_o = hi;
    #20 cs_n_o = 1'b0; // Margin to clock edges
    #12;
    for (int g = 0; g < ng; g++) begin
      for (int k = 0; k < 16; k++) begin
        sclk_o = 1'b0;
        din_o = (k < 8) ? cw[8*g+7-k] : ~din_o; // Stable around rising
        #6 sclk_o = 1'b1;
        word_o = {word_o[14:0], dout_i};
        #6;
      end
      word_cnt_o++;
    end
    cs_n_o = 1'b1;
  endtask
  // Clock runs while select is high; it must have no effect
  task automatic idle_clocks(input int n);
    repeat (n) begin
      #6 sclk_o = ~sclk_o;
    end
  endtask
endmodule

/* qas_pkg.sv */
// Constants for the four-channel converter serial port.
// Assumes a host master driving frame select, serial clock and control input.

package qas_pkg;

  // ---------------------------------------------------------------
  // Frame and conversion cycle layout
  // ---------------------------------------------------------------
  localparam int QAS_CYCLE_CLKS = 16;
  localparam int QAS_DATA_BITS = 8;
  localparam int QAS_CHAN_BITS = 2;
  localparam logic [3:0] QAS_CTRL_LAST = 4'h7;
  localparam logic [4:0] QAS_HOLD_FALL = 5'h04;
  localparam logic [4:0] QAS_FIRST_BIT_FALL = 5'h05;
  localparam logic [4:0] QAS_PDN_FALL = 5'h10;
  localparam logic [4:0] QAS_FALL_AT_START = 5'h01;

  // ---------------------------------------------------------------
  // Control word fields
  // ---------------------------------------------------------------
  localparam int QAS_CHAN_HI_POS = 4;
  localparam int QAS_CHAN_LO_POS = 3;

  // ---------------------------------------------------------------
  // Values after reset
  // ---------------------------------------------------------------
  localparam logic [1:0] QAS_DEFAULT_CHAN = 2'h0;
  localparam logic [7:0] QAS_RESULT_RST = 8'h00;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int QAS_CLK_PERIOD_PS = 8000;
  localparam int QAS_FRAME_MARGIN_NS = 10;
  localparam int QAS_FRAME_MARGIN_CLKS =
    (QAS_FRAME_MARGIN_NS * 1000 + QAS_CLK_PERIOD_PS - 1) / QAS_CLK_PERIOD_PS;

endpackage

/* qas_serial_port.sv */
// Serial framing and conversion sequencing of a four-channel 8-bit converter.
// Assumes the host owns the serial clock; the system side supplies samples on CLK_I.

`timescale 1ns/1ps

module qas_serial_port #(
  parameter int DATA_W = qas_pkg::QAS_DATA_BITS,
  parameter int CHAN_W = qas_pkg::QAS_CHAN_BITS
) (
  // System clock and reset
  input wire logic CLK_I,
  input wire logic RST_I,
  // Serial link
  input wire logic LINK_SCLK_I,
  input wire logic LINK_CS_N_I,
  input wire logic LINK_DIN_I,
  output logic LINK_DOUT_O,
  output logic LINK_DOUT_OE_O,
  // Sample source
  input wire logic [DATA_W-1:0] SAMPLE_I,
  output logic [CHAN_W-1:0] SAMPLE_CHAN_O,
  // Status
  output logic TRACK_O,
  output logic POWER_DOWN_O,
  output logic [CHAN_W-1:0] CONV_CHAN_O
);

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  localparam logic [4:0] LAST_BIT_FALL = 5'(qas_pkg::QAS_FIRST_BIT_FALL + DATA_W - 1);

  function automatic logic in_data_window(input logic [4:0] n);
    in_data_window = (n >= qas_pkg::QAS_FIRST_BIT_FALL) && (n <= LAST_BIT_FALL);
  endfunction

  function automatic int bit_index(input logic [4:0] n);
    bit_index = int'(LAST_BIT_FALL) - int'(n);
  endfunction

  // ---------------------------------------------------------------
  // Link domain: rising-edge side
  // ---------------------------------------------------------------
  logic [3:0] rise_cnt_q;
  logic [7:0] ctl_q;
  logic [7:0] ctl_word;
  logic [CHAN_W-1:0] pending_q;
  logic [DATA_W-1:0] stash_q;
  logic req_s1_q;
  logic req_s2_q;
  logic seen_q;
  logic req_q;
  logic [DATA_W-1:0] data_q;

  assign ctl_word = {ctl_q[6:0], LINK_DIN_I};

  // Position within the 16-clock group, cleared while select is high
  always_ff @(posedge LINK_SCLK_I or posedge LINK_CS_N_I) begin
    if (LINK_CS_N_I) begin
      rise_cnt_q <= 4'h0;
    end else begin
      rise_cnt_q <= rise_cnt_q + 4'h1;
    end
  end

  // Control word shift
  always_ff @(posedge LINK_SCLK_I or posedge LINK_CS_N_I) begin
    if (LINK_CS_N_I) begin
      ctl_q <= 8'h00;
    end else if (rise_cnt_q <= qas_pkg::QAS_CTRL_LAST) begin
      ctl_q <= ctl_word;
    end
  end

  // Pending channel for the next conversion
  always_ff @(posedge LINK_SCLK_I or posedge RST_I) begin
    if (RST_I) begin
      pending_q <= qas_pkg::QAS_DEFAULT_CHAN;
    end else if (!LINK_CS_N_I && rise_cnt_q == qas_pkg::QAS_CTRL_LAST) begin
      pending_q <= ctl_word[qas_pkg::QAS_CHAN_HI_POS:qas_pkg::QAS_CHAN_LO_POS];
    end
  end

  // Sample word handshake receiver
  always_ff @(posedge LINK_SCLK_I or posedge RST_I) begin
    if (RST_I) begin
      req_s1_q <= 1'b0;
      req_s2_q <= 1'b0;
    end else begin
      req_s1_q <= req_q;
      req_s2_q <= req_s1_q;
    end
  end

  always_ff @(posedge LINK_SCLK_I or posedge RST_I) begin
    if (RST_I) begin
      seen_q <= 1'b0;
    end else if (req_s2_q != seen_q) begin
      seen_q <= req_s2_q;
    end
  end

  // Sample word taken once the request toggle has settled
  always_ff @(posedge LINK_SCLK_I or posedge RST_I) begin
    if (RST_I) begin
      stash_q <= qas_pkg::QAS_RESULT_RST;
    end else if (req_s2_q != seen_q) begin
      stash_q <= data_q;
    end
  end

  // ---------------------------------------------------------------
  // Link domain: falling-edge side
  // ---------------------------------------------------------------
  logic [4:0] fall_n_q;
  logic [4:0] fall_n_d;
  logic [DATA_W-1:0] result_q;
  logic [CHAN_W-1:0] conv_chan_q;
  logic dout_q;
  logic track_q;
  logic pdn_q;

  assign fall_n_d = {1'b0, rise_cnt_q} + 5'h01;

  // Falling edge number in the group; select fall itself counts as the first
  always_ff @(negedge LINK_SCLK_I or posedge LINK_CS_N_I) begin
    if (LINK_CS_N_I) begin
      fall_n_q <= qas_pkg::QAS_FALL_AT_START;
    end else begin
      fall_n_q <= fall_n_d;
    end
  end

  // Mode: track, hold/convert, power-down gap
  always_ff @(negedge LINK_SCLK_I or posedge LINK_CS_N_I) begin
    if (LINK_CS_N_I) begin
      track_q <= 1'b1;
    end else begin
      track_q <= (fall_n_d < qas_pkg::QAS_HOLD_FALL);
    end
  end

  // Power-down gap between conversion cycles
  always_ff @(negedge LINK_SCLK_I or posedge LINK_CS_N_I) begin
    if (LINK_CS_N_I) begin
      pdn_q <= 1'b0;
    end else begin
      pdn_q <= (fall_n_d == qas_pkg::QAS_PDN_FALL);
    end
  end

  // Hold: freeze the sample and the channel it belongs to
  always_ff @(negedge LINK_SCLK_I or posedge RST_I) begin
    if (RST_I) begin
      result_q <= qas_pkg::QAS_RESULT_RST;
    end else if (!LINK_CS_N_I && fall_n_d == qas_pkg::QAS_HOLD_FALL) begin
      result_q <= stash_q;
    end
  end

  // Channel of the conversion now held
  always_ff @(negedge LINK_SCLK_I or posedge RST_I) begin
    if (RST_I) begin
      conv_chan_q <= qas_pkg::QAS_DEFAULT_CHAN;
    end else if (!LINK_CS_N_I && fall_n_d == qas_pkg::QAS_HOLD_FALL) begin
      conv_chan_q <= pending_q;
    end
  end

  // Result shifter, MSB first, zeros around the data bits
  always_ff @(negedge LINK_SCLK_I or posedge LINK_CS_N_I) begin
    if (LINK_CS_N_I) begin
      dout_q <= 1'b0;
    end else if (in_data_window(fall_n_d)) begin
      dout_q <= result_q[bit_index(fall_n_d)];
    end else begin
      dout_q <= 1'b0;
    end
  end

  assign LINK_DOUT_O = dout_q;
  assign LINK_DOUT_OE_O = ~LINK_CS_N_I;

  // ---------------------------------------------------------------
  // System domain: sample word handshake sender
  // ---------------------------------------------------------------
  logic ack_s1_q;
  logic ack_s2_q;

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      ack_s1_q <= 1'b0;
      ack_s2_q <= 1'b0;
    end else begin
      ack_s1_q <= seen_q;
      ack_s2_q <= ack_s1_q;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      req_q <= 1'b0;
    end else if (ack_s2_q == req_q) begin
      req_q <= ~req_q;
    end
  end

  // Sample word held steady while the request is open
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      data_q <= qas_pkg::QAS_RESULT_RST;
    end else if (ack_s2_q == req_q) begin
      data_q <= SAMPLE_I;
    end
  end

  // ---------------------------------------------------------------
  // System domain: status synchronisers
  // ---------------------------------------------------------------
  logic cs_s1_q;
  logic cs_s2_q;
  logic track_s1_q;
  logic track_s2_q;
  logic pdn_s1_q;
  logic pdn_s2_q;
  logic [CHAN_W-1:0] pend_s1_q;
  logic [CHAN_W-1:0] pend_s2_q;
  logic [CHAN_W-1:0] pend_s3_q;
  logic [CHAN_W-1:0] conv_s1_q;
  logic [CHAN_W-1:0] conv_s2_q;
  logic [CHAN_W-1:0] conv_s3_q;

  // Frame select
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      cs_s1_q <= 1'b1;
      cs_s2_q <= 1'b1;
    end else begin
      cs_s1_q <= LINK_CS_N_I;
      cs_s2_q <= cs_s1_q;
    end
  end

  // Track mode
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      track_s1_q <= 1'b0;
      track_s2_q <= 1'b0;
    end else begin
      track_s1_q <= track_q;
      track_s2_q <= track_s1_q;
    end
  end

  // Power-down gap
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      pdn_s1_q <= 1'b0;
      pdn_s2_q <= 1'b0;
    end else begin
      pdn_s1_q <= pdn_q;
      pdn_s2_q <= pdn_s1_q;
    end
  end

  // Pending channel
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      pend_s1_q <= qas_pkg::QAS_DEFAULT_CHAN;
      pend_s2_q <= qas_pkg::QAS_DEFAULT_CHAN;
      pend_s3_q <= qas_pkg::QAS_DEFAULT_CHAN;
    end else begin
      pend_s1_q <= pending_q;
      pend_s2_q <= pend_s1_q;
      pend_s3_q <= pend_s2_q;
    end
  end

  // Converted channel
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      conv_s1_q <= qas_pkg::QAS_DEFAULT_CHAN;
      conv_s2_q <= qas_pkg::QAS_DEFAULT_CHAN;
      conv_s3_q <= qas_pkg::QAS_DEFAULT_CHAN;
    end else begin
      conv_s1_q <= conv_chan_q;
      conv_s2_q <= conv_s1_q;
      conv_s3_q <= conv_s2_q;
    end
  end

  // ---------------------------------------------------------------
  // System domain: registered status outputs
  // ---------------------------------------------------------------
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      TRACK_O <= 1'b0;
    end else begin
      TRACK_O <= ~cs_s2_q & track_s2_q;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      POWER_DOWN_O <= 1'b1;
    end else begin
      POWER_DOWN_O <= cs_s2_q | pdn_s2_q;
    end
  end

  // Channel buses pass only once two samples agree
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      SAMPLE_CHAN_O <= qas_pkg::QAS_DEFAULT_CHAN;
    end else if (pend_s2_q == pend_s3_q) begin
      SAMPLE_CHAN_O <= pend_s3_q;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      CONV_CHAN_O <= qas_pkg::QAS_DEFAULT_CHAN;
    end else if (conv_s2_q == conv_s3_q) begin
      CONV_CHAN_O <= conv_s3_q;
    end
  end

endmodule

/* qas_serial_port_chk.sv */
// Assertions on the serial port pins and status outputs.
// Assumes a bind to qas_serial_port; everything is sampled on CLK_I.
`timescale 1ns/1ps
module qas_serial_port_chk (
  // Clock and reset
  input wire logic CLK_I,
  input wire logic RST_I,
  // Watched ports
  input wire logic LINK_CS_N_I,
  input wire logic LINK_DOUT_O,
  input wire logic LINK_DOUT_OE_O,
  input wire logic TRACK_O,
  input wire logic POWER_DOWN_O
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (RST_I);
  // ---------------------------------------------------------------
  // Sequences
  // ---------------------------------------------------------------
  sequence idle_s; LINK_CS_N_I [*5]; endsequence
  sequence track_s; TRACK_O [*3] ##[1:5] !TRACK_O; endsequence
  sequence hold_s; (!TRACK_O && !POWER_DOWN_O) [*8]; endsequence
  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  oe_follow_a: assert property (LINK_DOUT_OE_O == !LINK_CS_N_I)
    else $error("output enable differs from select");
  dout_idle_a: assert property (LINK_CS_N_I && $past(LINK_CS_N_I) |-> !LINK_DOUT_O)
    else $error("result driven outside a frame");
  idle_pdn_a: assert property (idle_s |-> POWER_DOWN_O)
    else $error("no power down while idle");
  idle_track_a: assert property (idle_s |-> !TRACK_O)
    else $error("tracking while idle");
  start_track_a: assert property ($fell(LINK_CS_N_I) |-> ##[1:6] TRACK_O)
    else $error("no track after frame start");
  start_power_a: assert property ($fell(LINK_CS_N_I) |-> ##[1:7] !POWER_DOWN_O)
    else $error("no power up after frame start");
  track_len_a: assert property ($rose(TRACK_O) |-> track_s)
    else $error("track phase length wrong");
  hold_len_a: assert property ($fell(TRACK_O) |-> hold_s)
    else $error("hold phase cut short");
endmodule
bind qas_serial_port qas_serial_port_chk qas_serial_port_chk_inst (
  .CLK_I(CLK_I), .RST_I(RST_I), .LINK_CS_N_I(LINK_CS_N_I), .LINK_DOUT_O(LINK_DOUT_O),
  .LINK_DOUT_OE_O(LINK_DOUT_OE_O), .TRACK_O(TRACK_O), .POWER_DOWN_O(POWER_DOWN_O));

/* tb_quad_channel_adc_serial_port.sv */
// Self-checking bench for the four-channel converter serial port.
// Assumes the design, its checker and the host model are compiled first.
`timescale 1ns/1ps
module tb_quad_channel_adc_serial_port;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] sample = 8'h00;
  logic sclk, cs_n, din, dout;
  logic [15:0] word;
  logic [1:0] samp_chan, conv_chan;
  int word_cnt;
  int bad_count = 0;
  int check_count = 0;
  logic [31:0] seed = 32'h00017F40;
  logic [7:0] tab [4];
  logic [31:0] exp_q [$];
  always #4 clk = ~clk;
  qas_serial_port qas_serial_port_inst (.CLK_I(clk), .RST_I(rst), .LINK_SCLK_I(sclk), .LINK_CS_N_I(cs_n),
    .LINK_DIN_I(din), .LINK_DOUT_O(dout), .LINK_DOUT_OE_O(), .SAMPLE_I(sample), .SAMPLE_CHAN_O(samp_chan),
    .TRACK_O(), .POWER_DOWN_O(), .CONV_CHAN_O(conv_chan));
  qas_host_model qas_host_model_inst (.sclk_o(sclk), .cs_n_o(cs_n), .din_o(din), .dout_i(dout),
    .word_o(word), .word_cnt_o(word_cnt));
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    check_count++;
    if (seen !== want) begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Input stand-in follows the requested channel
  always @(negedge clk) sample <= rst ? 8'h00 : tab[samp_chan];
  always @(word_cnt) begin
    logic [31:0] e;
    if (word_cnt > 0) begin
      e = exp_q.pop_front();
      check(word & e[31:16], e[15:0]);
    end
  end
  initial begin
    #300000;
    bad_count++;
    print_verdict();
  end
  initial begin
    logic [1:0] nxt, last;
    logic [31:0] cw;
    int ng;
    for (int i = 0; i < 4; i++) tab[i] = 8'(xs());
    repeat (3) @(negedge clk);
    rst <= 1'b0;
    repeat (10) @(negedge clk);
    exp_q.push_back(32'hF00F_0000);
    qas_host_model_inst.run_frame(1, 1'b0, 32'h0000_0010);
    repeat (8) @(negedge clk);
    check({14'h0, conv_chan}, 16'h0000);
    qas_host_model_inst.idle_clocks(16);
    nxt = 2'h2;
    for (int t = 0; t < 8; t++) begin
      ng = t % 4 + 1;
      for (int g = 0; g < ng; g++) begin
        cw[8*g +: 8] = (8'(xs()) & 8'hE7) | {3'h0, 2'(t + g), 3'h0};
        exp_q.push_back({16'hFFFF, 4'h0, tab[nxt], 4'h0});
        last = nxt;
        nxt = cw[8*g+3 +: 2];
      end
      qas_host_model_inst.run_frame(ng, t[0], cw);
      repeat (8) @(negedge clk);
      check({14'h0, conv_chan}, {14'h0, last});
      check({14'h0, samp_chan}, {14'h0, nxt});
      $display("frame %0d done", t);
      qas_host_model_inst.idle_clocks(16);
    end
    rst <= 1'b1;
    repeat (3) @(negedge clk);
    rst <= 1'b0;
    repeat (8) @(negedge clk);
    check({14'h0, samp_chan}, 16'h0000);
    $display("reset test done");
    print_verdict();
  end
endmodule
